// file: gdfp_core.sv
// protection and fault reporting core of a three-phase gate driver
`timescale 1ns/1ps
module gdfp_core #(
    parameter int WARN_CYC = gdfp_pkg::WARN_CYCLES,
    parameter int QUICK_CYC = gdfp_pkg::QUICK_RESET_CYCLES,
    parameter int FULL_CYC = gdfp_pkg::FULL_RESET_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] pwm_high,
    input wire logic [2:0] pwm_low,
    input wire logic [5:0] oc_detect,
    input wire logic main_supply_low_trip,
    input wire logic drive_supply_low_trip,
    input wire logic drive_supply_high_trip,
    input wire logic logic_supply_low,
    input wire logic thermal_warning,
    input wire logic thermal_trip,
    input wire logic enable_gate,
    input wire logic cfg_write,
    input wire logic [1:0] cfg_overcurrent_policy,
    input wire logic cfg_off_time,
    input wire logic [1:0] cfg_warn_select,
    input wire logic gate_reset_cmd,
    input wire logic status_read,
    output logic [2:0] high_gate_out,
    output logic [2:0] low_gate_out,
    output logic charge_pump_en,
    output logic shutdown_report_n_o,
    output logic shutdown_report_n_oe,
    output logic warning_report_n_o,
    output logic warning_report_n_oe,
    output logic [5:0] stat_overcurrent,
    output logic stat_fault,
    output logic stat_main_supply_low,
    output logic stat_drive_supply_low,
    output logic stat_drive_supply_high,
    output logic stat_thermal_warning,
    output logic stat_thermal_driver_shutdown,
    output logic [1:0] overcurrent_policy,
    output logic cycle_limit_control,
    output logic [1:0] warn_select
);
    import gdfp_pkg::*;
    initial begin
        if (WARN_CYC < 2) $error("warning period too short");
    end

    // ==========================================================
    // sub-blocks
    gdfp_timer_if tmr_if();
    gdfp_timer #(.CYCLES(WARN_CYC)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tmr(tmr_if.timer)
    );
    logic quick_reset;
    logic full_reset;
    logic enabled;
    gdfp_en_watch #(.QUICK_CYCLES(QUICK_CYC), .FULL_CYCLES(FULL_CYC)) u_en (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(enable_gate),
        .quick_reset(quick_reset),
        .full_reset(full_reset),
        .enabled(enabled)
    );

    // ==========================================================
    // state declarations
    logic [1:0] policy_reg;
    logic off_time_reg;
    logic [1:0] warn_sel_reg;
    logic [5:0] oc_stat_reg;
    logic [5:0] oc_stat_next;
    logic [5:0] cut_reg;
    logic [5:0] cut_next;
    logic [5:0] warn_src_reg;
    logic [5:0] warn_src_next;
    logic fault_oc_reg;
    logic ov_latch_reg;
    logic otsd_latch_reg;
    logic otw_stat_reg;
    logic uv_main_stat_reg;
    logic uv_drive_stat_reg;
    logic logic_low_reg;
    logic [5:0] pwm_prev_reg;

    // ==========================================================
    // pwm edge detection: a cycle of a transistor begins at its rising command
    wire logic [5:0] pwm_cmd = {pwm_low, pwm_high};
    wire logic [5:0] pwm_cycle = pwm_cmd & ~pwm_prev_reg;
    // no reset value: a parked-high command must not look like a fresh cycle after reset
    always_ff @(posedge sys_clk) begin
        pwm_prev_reg <= pwm_cmd;
    end

    // ==========================================================
    // decode of the policy and of the events
    wire logic pol_limit = (policy_reg == POLICY_LIMIT);
    wire logic pol_latch = (policy_reg == POLICY_LATCH);
    wire logic pol_report = (policy_reg == POLICY_REPORT);
    wire logic [5:0] oc_act = pol_latch ? oc_detect : 6'h00;
    wire logic [5:0] oc_rep = (policy_reg == POLICY_OFF) ? 6'h00 : oc_detect;
    wire logic oc_any = |oc_rep;
    // a trip on a transistor not yet in the current report extends it
    wire logic oc_new = |(oc_rep & ~warn_src_reg);
    wire logic uv_any = main_supply_low_trip | drive_supply_low_trip;
    wire logic gate_clear = gate_reset_cmd & ~main_supply_low_trip;
    wire logic soft_clear = gate_clear | quick_reset;
    wire logic stat_clear = rst | logic_low_reg & ~logic_supply_low;

    // ==========================================================
    // configuration; held at defaults in main supply undervoltage
    always_ff @(posedge sys_clk) begin
        if (rst || main_supply_low_trip || full_reset) begin
            policy_reg <= POLICY_RESET;
            off_time_reg <= OFF_TIME_RESET;
            warn_sel_reg <= WARN_SEL_RESET;
        end else if (cfg_write) begin
            policy_reg <= cfg_overcurrent_policy;
            off_time_reg <= cfg_off_time;
            warn_sel_reg <= cfg_warn_select;
        end
    end

    // ==========================================================
    // timer control
    assign tmr_if.restart = oc_any & (pol_limit | pol_report) & (oc_new | ~tmr_if.running);
    assign tmr_if.clear = ~(pol_limit | pol_report);

    // ==========================================================
    // per-transistor cut-off for current limiting
    always_comb begin
        cut_next = cut_reg;
        if (!pol_limit) begin
            cut_next = 6'h00;
        end else if (!off_time_reg) begin
            cut_next = (cut_reg & ~pwm_cycle) | oc_rep;
        end else begin
            cut_next = cut_reg & ~pwm_cycle;
            if (tmr_if.expired) cut_next = 6'h00;
            cut_next = cut_next | oc_rep;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || full_reset) cut_reg <= '0;
        else cut_reg <= cut_next;
    end

    // ==========================================================
    // warning sources: cleared by timer expiry or, in limit policy only, by all sources cycling
    always_comb begin
        warn_src_next = warn_src_reg & ~pwm_cycle;
        if (tmr_if.expired || !(pol_limit || pol_report)) warn_src_next = 6'h00;
        if (pol_report) warn_src_next = tmr_if.expired ? 6'h00 : warn_src_reg;
        warn_src_next = warn_src_next | oc_rep;
    end
    always_ff @(posedge sys_clk) begin
        if (rst || full_reset) warn_src_reg <= '0;
        else warn_src_reg <= warn_src_next;
    end
    wire logic oc_warn = (|warn_src_reg) | pol_latch & (|oc_stat_reg);

    // ==========================================================
    // overcurrent status bits; a new trip wins over the read clear
    assign oc_stat_next = ((status_read | gate_clear) ? 6'h00 : oc_stat_reg) | oc_rep;
    always_ff @(posedge sys_clk) begin
        if (rst || main_supply_low_trip) oc_stat_reg <= '0;
        else if (stat_clear || full_reset) oc_stat_reg <= oc_rep;
        else oc_stat_reg <= oc_stat_next;
    end

    // ==========================================================
    // latched overcurrent shutdown per half-bridge
    logic [2:0] bridge_off_reg;
    wire logic [2:0] bridge_trip = oc_act[2:0] | oc_act[5:3];
    always_ff @(posedge sys_clk) begin
        if (rst || full_reset) begin
            bridge_off_reg <= '0;
            fault_oc_reg <= 1'b0;
        end else begin
            bridge_off_reg <= (soft_clear ? 3'h0 : bridge_off_reg) | bridge_trip;
            fault_oc_reg <= (soft_clear ? 1'b0 : fault_oc_reg) | (|bridge_trip);
        end
    end

    // ==========================================================
    // overvoltage and thermal latches
    always_ff @(posedge sys_clk) begin
        if (rst) ov_latch_reg <= 1'b0;
        else if (drive_supply_high_trip) ov_latch_reg <= 1'b1;
        else if (full_reset) ov_latch_reg <= 1'b0;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            otsd_latch_reg <= 1'b0;
        end else if (thermal_trip) begin
            otsd_latch_reg <= 1'b1;
        end else if (soft_clear || full_reset) begin
            otsd_latch_reg <= 1'b0;
        end
    end

    // ==========================================================
    // supply and thermal warning status bits
    always_ff @(posedge sys_clk) begin
        if (rst) logic_low_reg <= 1'b1;
        else logic_low_reg <= logic_supply_low;
    end
    wire logic stat_wipe = status_read | gate_clear | stat_clear | full_reset;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            otw_stat_reg <= 1'b0;
            uv_main_stat_reg <= 1'b0;
            uv_drive_stat_reg <= 1'b0;
        end else begin
            otw_stat_reg <= thermal_warning | otw_stat_reg & ~stat_wipe; // a new event wins
            uv_main_stat_reg <= main_supply_low_trip;
            uv_drive_stat_reg <= drive_supply_low_trip | uv_drive_stat_reg & ~stat_wipe;
        end
    end

    // ==========================================================
    // gate outputs
    wire logic drive_off = uv_any | ov_latch_reg | otsd_latch_reg | ~enabled | logic_supply_low;
    wire logic [5:0] allow = ~cut_reg & ~{bridge_off_reg, bridge_off_reg};
    wire logic [5:0] gate_next = drive_off ? 6'h00 : pwm_cmd & allow;
    logic [5:0] gate_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) gate_reg <= '0;
        else gate_reg <= gate_next;
    end
    assign high_gate_out = gate_reg[2:0];
    assign low_gate_out = gate_reg[5:3];
    assign charge_pump_en = enabled & ~ov_latch_reg & ~otsd_latch_reg;

    // ==========================================================
    // report pins: open drain, enable high means pulling low
    wire logic fault_any = fault_oc_reg | ov_latch_reg | otsd_latch_reg | uv_any | ~enabled;
    wire logic warn_any = (warn_sel_reg == WARN_SEL_THERMAL) ? thermal_warning :
                          (warn_sel_reg == WARN_SEL_OVERCURRENT) ? oc_warn :
                          (thermal_warning | oc_warn);
    logic fault_pin_reg;
    logic warn_pin_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_pin_reg <= 1'b1;
            warn_pin_reg <= 1'b0;
        end else begin
            fault_pin_reg <= fault_any;
            warn_pin_reg <= warn_any | otsd_latch_reg;
        end
    end
    assign shutdown_report_n_o = 1'b0;
    assign shutdown_report_n_oe = fault_pin_reg;
    assign warning_report_n_o = 1'b0;
    assign warning_report_n_oe = warn_pin_reg;

    // ==========================================================
    // status and configuration views
    assign stat_overcurrent = oc_stat_reg;
    assign stat_fault = fault_pin_reg;
    assign stat_main_supply_low = uv_main_stat_reg;
    assign stat_drive_supply_low = uv_drive_stat_reg;
    assign stat_drive_supply_high = ov_latch_reg;
    assign stat_thermal_warning = otw_stat_reg;
    assign stat_thermal_driver_shutdown = otsd_latch_reg;
    assign overcurrent_policy = policy_reg;
    assign cycle_limit_control = ~off_time_reg;
    assign warn_select = warn_sel_reg;
endmodule

// file: gdfp_core_asserts.sv
// concurrent checks on the ports of the gate driver fault protection core
`timescale 1ns/1ps
module gdfp_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] oc_detect,
    input wire logic main_supply_low_trip,
    input wire logic drive_supply_low_trip,
    input wire logic logic_supply_low,
    input wire logic enable_gate,
    input wire logic cfg_write,
    input wire logic status_read,
    input wire logic [2:0] high_gate_out,
    input wire logic [2:0] low_gate_out,
    input wire logic shutdown_report_n_o,
    input wire logic shutdown_report_n_oe,
    input wire logic warning_report_n_o,
    input wire logic warning_report_n_oe,
    input wire logic [5:0] stat_overcurrent,
    input wire logic stat_fault,
    input wire logic stat_drive_supply_high,
    input wire logic [1:0] overcurrent_policy,
    input wire logic cycle_limit_control,
    input wire logic [1:0] warn_select
);
    import gdfp_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // supplies, pins and configuration
    a_uv_gates_off: assert property (
        (main_supply_low_trip || drive_supply_low_trip) |=> {high_gate_out, low_gate_out} == 6'h00)
        else $error("gates not low under undervoltage");
    a_uv_fault_pin: assert property (
        (main_supply_low_trip || drive_supply_low_trip) |-> ##[1:2] shutdown_report_n_oe)
        else $error("fault pin not asserted under undervoltage");
    a_pins_pull_low: assert property (
        shutdown_report_n_o == 1'b0 && warning_report_n_o == 1'b0)
        else $error("report pin drives a high level");
    a_uv_cfg_default: assert property (
        main_supply_low_trip |=> overcurrent_policy == POLICY_RESET
            && cycle_limit_control == ~OFF_TIME_RESET && warn_select == WARN_SEL_RESET)
        else $error("configuration kept under main undervoltage");
    // ==========================================================
    // overcurrent handling and the overvoltage latch
    a_oc_sets_bit: assert property (
        (oc_detect != 6'h00 && overcurrent_policy != POLICY_OFF && enable_gate && !cfg_write
            && !main_supply_low_trip && !logic_supply_low && !shutdown_report_n_oe)
        |=> (stat_overcurrent & $past(oc_detect)) == $past(oc_detect))
        else $error("overcurrent status bit not set");
    a_read_clears: assert property (
        (status_read && oc_detect == 6'h00) |=> stat_overcurrent == 6'h00)
        else $error("overcurrent status kept after read");
    a_latch_phase_off: assert property (
        (overcurrent_policy == POLICY_LATCH && (oc_detect[0] || oc_detect[3]) && !cfg_write
            && !main_supply_low_trip) |=> ##1 (!high_gate_out[0] && !low_gate_out[0]))
        else $error("half bridge still driven after latched trip");
    a_ov_latched: assert property (
        (enable_gate && !logic_supply_low && !main_supply_low_trip) [*4] ##0 stat_drive_supply_high
        |=> stat_drive_supply_high)
        else $error("overvoltage latch released with enable high");
    c_latch_fault: cover property (overcurrent_policy == POLICY_LATCH && stat_fault);
    c_ov_trip: cover property ($rose(stat_drive_supply_high));
    c_report_warn: cover property (overcurrent_policy == POLICY_REPORT && warning_report_n_oe);
endmodule
bind gdfp_core gdfp_asserts u_asserts (.*);

// file: gdfp_core_tb.sv
// self-checking testbench for the gate driver fault protection core
`timescale 1ns/1ps
module gdfp_core_tb;
    import gdfp_pkg::*;
    localparam int WARN = 20;
    localparam int QUICK = 5;
    localparam int FULL = 10;
    logic sys_clk, rst, pwm_run, main_supply_low_trip, drive_supply_low_trip, logic_supply_low;
    logic drive_supply_high_trip, thermal_warning, thermal_trip, enable_gate, cfg_write;
    logic cfg_off_time, gate_reset_cmd, status_read, charge_pump_en, fault_line_n;
    logic shutdown_report_n_o, shutdown_report_n_oe, warning_report_n_o, warning_report_n_oe;
    logic stat_fault, stat_main_supply_low, stat_drive_supply_low, stat_drive_supply_high;
    logic stat_thermal_warning, stat_thermal_driver_shutdown, cycle_limit_control;
    logic [1:0] cfg_overcurrent_policy, cfg_warn_select, overcurrent_policy, warn_select, m_pol;
    logic [2:0] pwm_high, pwm_low, high_gate_out, low_gate_out;
    logic [5:0] oc_detect, stat_overcurrent;
    int n_fail = 0;
    int n_compared = 0;
    int exp_oc = 0;
    int seed = 32'h3127_5589;
    int k, cnt;
    gdfp_host host (.sys_clk(sys_clk), .pwm_run(pwm_run), .fault_n_o(shutdown_report_n_o),
        .fault_n_oe(shutdown_report_n_oe), .pwm_high(pwm_high), .pwm_low(pwm_low),
        .enable_gate(enable_gate), .fault_line_n(fault_line_n));
    gdfp_core #(.WARN_CYC(WARN), .QUICK_CYC(QUICK), .FULL_CYC(FULL)) dut (.*);
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // overcurrent status bits against the behavioural model
    task automatic chk_stat();
        chk("stat_overcurrent", exp_oc[7:0], 8'(stat_overcurrent));
    endtask
    task automatic cfg(input logic [1:0] pol, input logic off, input logic [1:0] sel);
        cfg_write = 1'b1;
        cfg_overcurrent_policy = pol;
        cfg_off_time = off;
        cfg_warn_select = sel;
        m_pol = pol;
        tick(1);
        cfg_write = 1'b0;
        tick(1);
    endtask
    // one-cycle trip on transistor i; the model latches it unless disabled
    task automatic trip(input int i);
        oc_detect = 6'h01 << i;
        if (m_pol != POLICY_OFF) begin
            exp_oc = exp_oc | (1 << i);
        end
        tick(1);
        oc_detect = 6'h00;
        tick(2);
    endtask
    task automatic read_stat();
        status_read = 1'b1;
        exp_oc = 0;
        tick(1);
        status_read = 1'b0;
        tick(1);
    endtask
    task automatic greset();
        gate_reset_cmd = 1'b1;
        tick(1);
        gate_reset_cmd = 1'b0;
        tick(3);
    endtask
    task automatic wait_warn(input logic val, input int lim);
        cnt = 0;
        while (warning_report_n_oe !== val && cnt < lim) begin
            tick(1);
            cnt++;
        end
        chk("warn_wait", 8'(val), 8'(warning_report_n_oe));
        if (warning_report_n_oe !== val) begin
            tally_and_finish();
        end
    endtask
    // main sequence
    initial begin
        {rst, pwm_run, main_supply_low_trip, drive_supply_low_trip, logic_supply_low} = 5'h10;
        {drive_supply_high_trip, thermal_warning, thermal_trip, cfg_write, cfg_off_time} = 5'h00;
        {gate_reset_cmd, status_read, cfg_overcurrent_policy, cfg_warn_select} = 6'h00;
        oc_detect = 6'h00;
        m_pol = POLICY_RESET;
        tick(2);
        rst = 1'b0;
        tick(1);
        chk("policy", 8'(POLICY_RESET), 8'(overcurrent_policy));
        chk("cycle_limit", 8'h01, 8'(cycle_limit_control));
        chk("fault_oe", 8'h01, 8'(shutdown_report_n_oe));
        host.pulse_enable(1);
        tick(6);
        chk("fault_line", 8'h01, 8'(fault_line_n));
        k = $unsigned($random(seed)) % 3;
        trip(k);
        chk("high_gate", 8'(3'h7 & ~(3'h1 << k)), 8'(high_gate_out));
        chk("warn", 8'h01, 8'(warning_report_n_oe));
        chk_stat();
        pwm_run = 1'b1;
        wait_warn(1'b0, WARN - 6);
        pwm_run = 1'b0;
        tick(2);
        chk("high_gate", 8'h07, 8'(high_gate_out));
        read_stat();
        chk_stat();
        cfg(POLICY_LIMIT, 1'b1, WARN_SEL_BOTH);
        chk("cycle_limit", 8'h00, 8'(cycle_limit_control));
        trip(k);
        tick(8);
        trip((k + 1) % 3);
        tick(WARN - 6);
        chk("high_gate", 8'(3'h7 & ~(3'h1 << k) & ~(3'h1 << ((k + 1) % 3))), 8'(high_gate_out));
        chk("warn", 8'h01, 8'(warning_report_n_oe));
        wait_warn(1'b0, 10);
        tick(1);
        chk("high_gate", 8'h07, 8'(high_gate_out));
        trip(k);
        pwm_run = 1'b1;
        tick(7);
        pwm_run = 1'b0;
        tick(2);
        chk("high_gate", 8'h07, 8'(high_gate_out));
        read_stat();
        tick(WARN);
        cfg(POLICY_LATCH, 1'b0, WARN_SEL_BOTH);
        for (int r = 0; r < 2; r++) begin
            k = $unsigned($random(seed)) % 6;
            trip(k);
            chk("high_gate", 8'(3'h7 & ~(3'h1 << (k % 3))), 8'(high_gate_out));
            chk("fault", 8'h03, 8'({stat_fault, shutdown_report_n_oe}));
            chk_stat();
            read_stat();
            chk_stat();
            chk("fault", 8'h01, 8'(stat_fault));
            if (r == 0) begin
                greset();
            end else begin
                host.pulse_enable(QUICK - 2);
                tick(4);
            end
            chk("fault", 8'h00, 8'({stat_fault, shutdown_report_n_oe}));
        end
        for (int s = 0; s < 3; s++) begin
            cfg(POLICY_REPORT, 1'b0, 2'(s));
            trip(k % 3);
            chk("high_gate", 8'h07, 8'(high_gate_out));
            chk_stat();
            chk("warn", 8'(s != 1), 8'(warning_report_n_oe));
            tick(WARN - 8);
            chk("warn", 8'(s != 1), 8'(warning_report_n_oe));
            tick(10);
            chk("warn", 8'h00, 8'(warning_report_n_oe));
            thermal_warning = 1'b1;
            tick(3);
            chk("warn", 8'(s != 2), 8'(warning_report_n_oe));
            chk("otw_stat", 8'h01, 8'(stat_thermal_warning));
            thermal_warning = 1'b0;
            tick(3);
            read_stat();
        end
        cfg(POLICY_OFF, 1'b0, WARN_SEL_BOTH);
        trip(2);
        chk_stat();
        chk("warn", 8'h00, 8'(warning_report_n_oe));
        drive_supply_low_trip = 1'b1;
        tick(3);
        chk("gates", 8'h00, 8'({high_gate_out, low_gate_out}));
        chk("uv_drive", 8'h03, 8'({stat_drive_supply_low, shutdown_report_n_oe}));
        drive_supply_low_trip = 1'b0;
        main_supply_low_trip = 1'b1;
        cfg(POLICY_LATCH, 1'b1, WARN_SEL_THERMAL);
        m_pol = POLICY_RESET;
        chk("config", 8'h01, 8'(overcurrent_policy == POLICY_RESET && cycle_limit_control));
        chk("warn_sel", 8'({1'b1, WARN_SEL_RESET}), 8'({stat_main_supply_low, warn_select}));
        main_supply_low_trip = 1'b0;
        drive_supply_high_trip = 1'b1;
        tick(2);
        drive_supply_high_trip = 1'b0;
        greset();
        host.pulse_enable(QUICK - 2);
        tick(4);
        chk("ov", 8'h10, 8'({stat_drive_supply_high, charge_pump_en, high_gate_out}));
        host.pulse_enable(FULL + 3);
        tick(6);
        chk("ov", 8'h0f, 8'({stat_drive_supply_high, charge_pump_en, high_gate_out}));
        thermal_trip = 1'b1;
        tick(3);
        greset();
        chk("tsd", 8'h18, 8'({stat_thermal_driver_shutdown, shutdown_report_n_oe, high_gate_out}));
        cfg(POLICY_REPORT, 1'b1, WARN_SEL_BOTH);
        chk("policy", 8'(POLICY_REPORT), 8'(overcurrent_policy));
        thermal_trip = 1'b0;
        tick(3);
        chk("tsd", 8'h01, 8'(stat_thermal_driver_shutdown));
        greset();
        chk("tsd", 8'h07, 8'({stat_thermal_driver_shutdown, shutdown_report_n_oe, high_gate_out}));
        trip(4);
        chk_stat();
        logic_supply_low = 1'b1;
        tick(3);
        logic_supply_low = 1'b0;
        exp_oc = 0;
        tick(3);
        chk_stat();
        tally_and_finish();
    end
endmodule

// file: gdfp_en_watch.sv
// enable pin watcher that classifies low pulses as quick or full resets
`timescale 1ns/1ps
module gdfp_en_watch #(
    parameter int QUICK_CYCLES = 1000,
    parameter int FULL_CYCLES = 2000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    output logic quick_reset,
    output logic full_reset,
    output logic enabled
);
    import gdfp_pkg::*;
    localparam int W = $clog2(FULL_CYCLES + 2);
    initial begin
        if (QUICK_CYCLES < 1 || FULL_CYCLES <= QUICK_CYCLES) $error("bad reset windows");
    end
    gdfp_en_state_t state_reg;
    logic [W-1:0] low_count_reg;
    logic quick_reg;
    logic full_reg;
    wire logic long_low = (low_count_reg > W'(FULL_CYCLES));
    wire logic short_low = (low_count_reg < W'(QUICK_CYCLES));
    // ==========================================================
    // state machine; a rising edge out of idle is a full reset too
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= GDFP_EN_OFF;
            low_count_reg <= '0;
            quick_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            quick_reg <= 1'b0;
            full_reg <= 1'b0;
            unique case (state_reg)
                GDFP_EN_OFF: begin
                    if (enable) begin
                        state_reg <= GDFP_EN_ON;
                        full_reg <= 1'b1;
                    end
                end
                GDFP_EN_ON: begin
                    low_count_reg <= '0;
                    if (!enable) state_reg <= GDFP_EN_LOW;
                end
                GDFP_EN_LOW: begin
                    if (!long_low) low_count_reg <= low_count_reg + W'(1);
                    if (long_low) state_reg <= GDFP_EN_OFF;
                    else if (enable) begin
                        state_reg <= GDFP_EN_ON;
                        quick_reg <= short_low; // 10..20 us pulses are not served
                    end
                end
            endcase
        end
    end
    assign quick_reset = quick_reg;
    assign full_reset = full_reg;
    assign enabled = (state_reg == GDFP_EN_ON);
endmodule

// file: gdfp_host.sv
// host side model: pwm generator, enable pin driver and fault line pull-up
`timescale 1ns/1ps
module gdfp_host (
    input wire logic sys_clk,
    input wire logic pwm_run,
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    output logic [2:0] pwm_high,
    output logic [2:0] pwm_low,
    output logic enable_gate,
    output logic fault_line_n
);
    int cnt_reg = 0;
    initial enable_gate = 1'b0;
    // eight-cycle pwm while running; high sides parked on otherwise
    always @(negedge sys_clk) begin
        cnt_reg <= pwm_run ? cnt_reg + 1 : 0;
    end
    assign pwm_high = (pwm_run && !cnt_reg[2]) ? 3'h0 : 3'h7;
    assign pwm_low = ~pwm_high;
    // pull-up on the open-drain line: low only while the device drives it
    assign fault_line_n = fault_n_oe ? fault_n_o : 1'b1;
    // enable low pulse: short ones clear faults quickly, long ones fully
    task automatic pulse_enable(input int lo_cycles);
        enable_gate = 1'b0;
        repeat (lo_cycles) @(negedge sys_clk);
        enable_gate = 1'b1;
    endtask
endmodule

// file: gdfp_pkg.sv
// package of constants and types for the gate driver fault protection block
package gdfp_pkg;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int WARN_TIME_US = 64;
    localparam int WARN_CYCLES = WARN_TIME_US * CLK_MHZ;
    localparam int QUICK_RESET_US = 10;
    localparam int QUICK_RESET_CYCLES = QUICK_RESET_US * CLK_MHZ;
    localparam int FULL_RESET_US = 20;
    localparam int FULL_RESET_CYCLES = FULL_RESET_US * CLK_MHZ;
    // ==========================================================
    // overcurrent policy encodings
    localparam logic [1:0] POLICY_LIMIT = 2'h0;
    localparam logic [1:0] POLICY_LATCH = 2'h1;
    localparam logic [1:0] POLICY_REPORT = 2'h2;
    localparam logic [1:0] POLICY_OFF = 2'h3;
    // warning pin report selection
    localparam logic [1:0] WARN_SEL_BOTH = 2'h0;
    localparam logic [1:0] WARN_SEL_THERMAL = 2'h1;
    localparam logic [1:0] WARN_SEL_OVERCURRENT = 2'h2;
    // ==========================================================
    // reset values of configuration
    localparam logic [1:0] POLICY_RESET = POLICY_LIMIT;
    localparam logic OFF_TIME_RESET = 1'b0; // cycle-limit after reset
    localparam logic [1:0] WARN_SEL_RESET = WARN_SEL_BOTH;
    // enable-pin watcher states
    typedef enum logic [2:0] {
        GDFP_EN_OFF = 3'b001,
        GDFP_EN_ON = 3'b010,
        GDFP_EN_LOW = 3'b100
    } gdfp_en_state_t;
endpackage

// file: gdfp_timer.sv
// restartable 64 us period timer counted in clock cycles
`timescale 1ns/1ps
module gdfp_timer #(
    parameter int CYCLES = 6400
) (
    input wire logic sys_clk,
    input wire logic rst,
    gdfp_timer_if.timer tmr
);
    import gdfp_pkg::*;
    localparam int W = $clog2(CYCLES + 1);
    initial begin
        if (CYCLES < 2) $error("timer period too short");
    end
    logic [W-1:0] count_reg;
    logic expired_reg;
    // ==========================================================
    // counter
    // clear wins over restart, and restart wins over expiry
    always_ff @(posedge sys_clk) begin
        if (rst || tmr.clear) begin
            count_reg <= '0;
            expired_reg <= 1'b0;
        end else if (tmr.restart) begin
            count_reg <= W'(CYCLES);
            expired_reg <= 1'b0;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
            expired_reg <= (count_reg == W'(1));
        end else begin
            expired_reg <= 1'b0;
        end
    end
    assign tmr.running = (count_reg != '0);
    assign tmr.expired = expired_reg;
endmodule

// file: gdfp_timer_if.sv
// interface between the protection core and its 64 us timer
`timescale 1ns/1ps
interface gdfp_timer_if;
    logic restart;
    logic clear;
    logic running;
    logic expired;
    modport core (output restart, output clear, input running, input expired);
    modport timer (input restart, input clear, output running, output expired);
endinterface
